// file: rtl/tcr_config_bank.sv
// Configuration bank of the TDC with Avalon-MM slave, interrupt status and result error fill
`include "tcr_params.svh"
`default_nettype none
module tcr_config_bank (
  input wire logic i_clk, // 250 MHz clock
  input wire logic i_reset, // Async reset, active high
  input wire logic [5:0] i_address, // Avalon byte address
  input wire logic i_read, // Avalon read
  input wire logic i_write, // Avalon write
  input wire logic [31:0] i_writedata, // Avalon write data
  input wire logic [3:0] i_byteenable, // Avalon byte enables
  output logic [31:0] o_readdata, // Avalon read data
  output logic o_waitrequest, // Avalon wait request
  input wire logic i_meas_start, // Core: measurement start pulse
  input wire logic i_timeout, // Core: timeout event pulse
  input wire logic i_end_hits, // Core: all hits seen pulse
  input wire logic i_alu_done, // Core: ALU finished pulse
  input wire logic [31:0] i_alu_diff, // Core: ALU difference
  output logic [31:0] o_alu_result, // Result, error fill applied
  output tcr_pkg::tcr_active_t o_cfg, // Settings of current measurement
  output logic o_irq // Interrupt, level
);

  // *************************************************
  // Helpers
  // *************************************************
  function automatic logic [23:0] tcr_merge(input logic [23:0] old, input logic [31:0] d, input logic [3:0] be);
    logic [23:0] r;
    r = old;
    for (int i = 0; i < 3; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    return r;
  endfunction : tcr_merge

  // Illegal hit counts 5..7 are clamped to four, the most the cores support
  function automatic logic [2:0] tcr_hits(input logic [2:0] h);
    return (h > `TCR_MAX_HITS) ? `TCR_MAX_HITS : h;
  endfunction : tcr_hits

  function automatic logic [15:0] tcr_timo(input logic [1:0] s);
    case (s)
      2'h0: return 16'(`TCR_TIMO_REF(`TCR_TIMO_US_0));
      2'h1: return 16'(`TCR_TIMO_REF(`TCR_TIMO_US_1));
      2'h2: return 16'(`TCR_TIMO_REF(`TCR_TIMO_US_2));
      default: return 16'(`TCR_TIMO_REF(`TCR_TIMO_US_3));
    endcase
  endfunction : tcr_timo

  // Checks operands against the range coding; range B takes a channel A stop minus start
  function automatic logic tcr_op_ok(input logic rb, input logic [3:0] a, input logic [3:0] b);
    logic ok_a;
    logic ok_b;
    if (rb) begin
      ok_a = (a == `TCR_SEL_R2_START);
      ok_b = (b >= `TCR_SEL_R2_STOP_LO) && (b <= `TCR_SEL_R2_STOP_HI);
    end else begin
      ok_a = (a != 4'h8) && (a <= 4'hc) && (a != `TCR_SEL_NONE);
      ok_b = (b != 4'h8) && (b <= 4'hc) && (b != `TCR_SEL_NONE);
    end
    return ok_a && ok_b;
  endfunction : tcr_op_ok

  function automatic tcr_pkg::tcr_active_t tcr_decode(input tcr_pkg::tcr_cfg_t c);
    tcr_pkg::tcr_active_t a;
    a.hits_a = tcr_hits(c.cfg1[`TCR_HITS_A_LSB +: 3]);
    a.hits_b = tcr_hits(c.cfg1[`TCR_HITS_B_LSB +: 3]);
    a.fast_init = c.cfg1[`TCR_FAST_INIT_BIT];
    a.op_a = c.cfg1[`TCR_OPA_LSB +: 4];
    a.op_b = c.cfg1[`TCR_OPB_LSB +: 4];
    a.range_b = c.ctrl[`TCR_RANGE_BIT];
    a.op_valid = tcr_op_ok(a.range_b, a.op_a, a.op_b);
    a.delay_a = c.cfg2[18:0];
    a.delay_b = c.cfg3[18:0];
    a.delay_c = c.cfg4[18:0];
    a.dual_a = c.cfg2[`TCR_DUAL_A_BIT];
    a.dual_b = c.cfg2[`TCR_DUAL_B_BIT];
    a.timeout_ref = tcr_timo(c.cfg3[`TCR_TIMO_LSB +: 2]);
    a.err_fill = c.cfg3[`TCR_ERRFILL_BIT];
    a.phase = c.cfg5[15:0];
    a.repeat_n = c.cfg5[`TCR_REPEAT_LSB +: 3];
    a.start_jitter = c.cfg5[`TCR_SJ_EN_BIT];
    a.pulse_a_en = ~c.cfg5[`TCR_DIS_A_BIT];
    a.pulse_b_en = ~c.cfg5[`TCR_DIS_B_BIT];
    a.pulse_b_inv = c.cfg5[`TCR_INV_B_BIT];
    return a;
  endfunction : tcr_decode

  // *************************************************
  // State
  // *************************************************
  tcr_pkg::tcr_state_t st_r;
  tcr_pkg::tcr_state_t st_nxt;
  logic [2:0] events;
  logic stat_rd;

  assign events = {i_timeout, i_end_hits, i_alu_done};

  // *************************************************
  // Next state
  // *************************************************
  always_comb begin
    st_nxt = st_r;
    stat_rd = 1'b0;
    st_nxt.bus.wait_n = 1'b0;
    // One wait cycle per access: request seen, answer on the following edge
    if ((i_read || i_write) && !st_r.bus.wait_n) begin
      st_nxt.bus.wait_n = 1'b1;
      st_nxt.bus.rdata = 32'h0;
      if (i_write) begin
        case (i_address)
          `TCR_OFF_W1: st_nxt.cfg.cfg1 = tcr_merge(st_r.cfg.cfg1, i_writedata, i_byteenable);
          `TCR_OFF_W2: st_nxt.cfg.cfg2 = tcr_merge(st_r.cfg.cfg2, i_writedata, i_byteenable);
          `TCR_OFF_W3: st_nxt.cfg.cfg3 = tcr_merge(st_r.cfg.cfg3, i_writedata, i_byteenable);
          `TCR_OFF_W4: st_nxt.cfg.cfg4 = tcr_merge(st_r.cfg.cfg4, i_writedata, i_byteenable);
          `TCR_OFF_W5: begin
            // Phase jitter unit must stay off; the bit is forced regardless of data
            st_nxt.cfg.cfg5 = tcr_merge(st_r.cfg.cfg5, i_writedata, i_byteenable);
            st_nxt.cfg.cfg5[`TCR_PJ_DIS_BIT] = 1'b1;
          end
          `TCR_OFF_CTRL: begin
            if (i_byteenable[0]) begin
              st_nxt.cfg.ctrl = i_writedata[7:0];
            end
          end
          `TCR_OFF_MASK: begin
            if (i_byteenable[0]) begin
              st_nxt.bus.mask = i_writedata[2:0];
            end
          end
          default: ;
        endcase
      end else begin
        case (i_address)
          `TCR_OFF_CTRL: st_nxt.bus.rdata = {24'h0, st_r.cfg.ctrl};
          `TCR_OFF_STAT: begin
            st_nxt.bus.rdata = {29'h0, st_r.bus.sts};
            stat_rd = 1'b1;
          end
          `TCR_OFF_MASK: st_nxt.bus.rdata = {29'h0, st_r.bus.mask};
          `TCR_OFF_ACT1: st_nxt.bus.rdata = {8'h0, st_r.act.op_b, st_r.act.op_a, st_r.act.fast_init,
                                             st_r.act.range_b, st_r.act.hits_b, st_r.act.hits_a,
                                             st_r.act.op_valid, 7'h0};
          default: st_nxt.bus.rdata = 32'h0;
        endcase
      end
    end
    // Write-only config words read as zero; reading status clears it, a new event wins
    if (stat_rd) begin
      st_nxt.bus.sts = 3'h0;
    end
    // Each source gated by its enable, then OR-ed onto the line
    st_nxt.bus.sts = st_nxt.bus.sts | (events & st_r.cfg.cfg2[`TCR_IRQ_ALU_BIT +: 3]);
    st_nxt.bus.irq = |(st_nxt.bus.sts & st_nxt.bus.mask);
    // Settings are latched only at a measurement start
    if (i_meas_start) begin
      st_nxt.act = tcr_decode(st_r.cfg);
    end
    if (i_alu_done) begin
      st_nxt.bus.alu_out = i_alu_diff;
    end
    if (i_timeout && st_r.act.err_fill) begin
      st_nxt.bus.alu_out = `TCR_ERR_FILL;
    end
  end

  // *************************************************
  // Registers
  // *************************************************
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      st_r.cfg <= '{cfg1: `TCR_RST_CFG1, cfg2: `TCR_RST_CFG2, cfg3: `TCR_RST_CFG3,
                    cfg4: `TCR_RST_CFG4, cfg5: `TCR_RST_CFG5, ctrl: `TCR_RST_CTRL};
      st_r.act <= '0;
      st_r.bus <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Active settings read all zero after reset; the defaults are loaded by the first start
  assign o_cfg = st_r.act;
  assign o_readdata = st_r.bus.rdata;
  assign o_waitrequest = ~st_r.bus.wait_n;
  assign o_irq = st_r.bus.irq;
  assign o_alu_result = st_r.bus.alu_out;

endmodule : tcr_config_bank
`default_nettype wire

// file: shared/tcr_params.svh
// Offsets, field positions, reset values and timing counts of the TDC configuration bank
`ifndef TCR_PARAMS_SVH
`define TCR_PARAMS_SVH

// Register byte offsets
`define TCR_OFF_CTRL 6'h18
`define TCR_OFF_STAT 6'h1c
`define TCR_OFF_MASK 6'h20
`define TCR_OFF_ACT1 6'h24
`define TCR_OFF_W1 6'h04
`define TCR_OFF_W2 6'h08
`define TCR_OFF_W3 6'h0c
`define TCR_OFF_W4 6'h10
`define TCR_OFF_W5 6'h14

// Reset values of the writable configuration words
`define TCR_RST_CFG1 24'h554000
`define TCR_RST_CFG2 24'h200000
`define TCR_RST_CFG3 24'h180000
`define TCR_RST_CFG4 24'h200000
`define TCR_RST_CFG5 24'h000000
`define TCR_RST_CTRL 8'h08

// Field positions
`define TCR_HITS_A_LSB 8
`define TCR_HITS_B_LSB 11
`define TCR_FAST_INIT_BIT 15
`define TCR_OPA_LSB 16
`define TCR_OPB_LSB 20
`define TCR_DUAL_A_BIT 19
`define TCR_DUAL_B_BIT 20
`define TCR_IRQ_ALU_BIT 21
`define TCR_IRQ_HITS_BIT 22
`define TCR_IRQ_TIMO_BIT 23
`define TCR_TIMO_LSB 19
`define TCR_ERRFILL_BIT 21
`define TCR_REPEAT_LSB 16
`define TCR_PJ_DIS_BIT 19
`define TCR_SJ_EN_BIT 20
`define TCR_DIS_A_BIT 21
`define TCR_DIS_B_BIT 22
`define TCR_INV_B_BIT 23
`define TCR_RANGE_BIT 3

// Selector codes
`define TCR_MAX_HITS 3'h4
`define TCR_SEL_NONE 4'h5
`define TCR_SEL_R2_START 4'h1
`define TCR_SEL_R2_STOP_LO 4'h2
`define TCR_SEL_R2_STOP_HI 4'h4
`define TCR_ERR_FILL 32'hffffffff

// Timeout times in microseconds at the nominal 4 MHz reference
`define TCR_TIMO_US_0 64
`define TCR_TIMO_US_1 256
`define TCR_TIMO_US_2 1024
`define TCR_TIMO_US_3 4096
`define TCR_REF_MHZ 4
`define TCR_TIMO_REF(us) ((us) * `TCR_REF_MHZ)

`endif

// file: shared/tcr_pkg.sv
// Types of the TDC configuration register bank
`default_nettype none
package tcr_pkg;
  typedef struct packed {
    logic [23:0] cfg1;
    logic [23:0] cfg2;
    logic [23:0] cfg3;
    logic [23:0] cfg4;
    logic [23:0] cfg5;
    logic [7:0] ctrl;
  } tcr_cfg_t;

  typedef struct packed {
    logic [2:0] hits_a;
    logic [2:0] hits_b;
    logic fast_init;
    logic [3:0] op_a;
    logic [3:0] op_b;
    logic range_b;
    logic op_valid;
    logic [18:0] delay_a;
    logic [18:0] delay_b;
    logic [18:0] delay_c;
    logic dual_a;
    logic dual_b;
    logic [15:0] timeout_ref;
    logic err_fill;
    logic [15:0] phase;
    logic [2:0] repeat_n;
    logic start_jitter;
    logic pulse_a_en;
    logic pulse_b_en;
    logic pulse_b_inv;
  } tcr_active_t;

  typedef struct packed {
    logic [2:0] sts;
    logic [2:0] mask;
    logic irq;
    logic [31:0] rdata;
    logic wait_n;
    logic [31:0] alu_out;
  } tcr_bus_t;

  typedef struct packed {
    tcr_cfg_t cfg;
    tcr_active_t act;
    tcr_bus_t bus;
  } tcr_state_t;
endpackage : tcr_pkg
`default_nettype wire

// file: sim/tcr_bank_assertions.sv
// Port checker of the TDC configuration bank
`default_nettype none
module tcr_bank_assertions (
  input wire logic i_clk, // Clock
  input wire logic i_reset, // Async reset
  input wire logic [5:0] i_address, // Bus address
  input wire logic i_read, // Bus read
  input wire logic i_write, // Bus write
  input wire logic i_meas_start, // Measurement start
  input wire logic i_timeout, // Timeout event
  input wire logic i_alu_done, // ALU done event
  input wire logic [31:0] i_alu_diff, // ALU data
  input wire logic [31:0] o_readdata, // Read data
  input wire logic o_waitrequest, // Wait request
  input wire logic [31:0] o_alu_result, // Result
  input wire tcr_pkg::tcr_active_t o_cfg // Active settings
);
  // ****************
  // Properties
  // ****************
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_reset);
  sequence s_taken; (i_read || i_write) && o_waitrequest; endsequence
  sequence s_answer; !o_waitrequest ##1 o_waitrequest; endsequence
  property p_answer; s_taken |=> s_answer; endproperty
  property p_quiet; !(i_read || i_write) && o_waitrequest |=> o_waitrequest; endproperty
  property p_wo_read; i_read && o_waitrequest && i_address == 6'h04 |=> o_readdata == 32'h0; endproperty
  property p_alu_pass; i_alu_done && !i_timeout |=> o_alu_result == $past(i_alu_diff); endproperty
  property p_err_fill; i_timeout && o_cfg.err_fill |=> o_alu_result == 32'hffffffff; endproperty
  property p_res_hold; !i_alu_done && !i_timeout |=> $stable(o_alu_result); endproperty
  property p_cfg_hold; !i_meas_start |=> $stable(o_cfg); endproperty
  property p_hits; o_cfg.hits_a <= 3'h4 && o_cfg.hits_b <= 3'h4; endproperty
  a_answer: assert property (p_answer) else $error("bus answer timing wrong");
  a_quiet: assert property (p_quiet) else $error("answer without request");
  a_wo_read: assert property (p_wo_read) else $error("write only word read back");
  a_alu_pass: assert property (p_alu_pass) else $error("result not taken from ALU");
  a_err_fill: assert property (p_err_fill) else $error("error fill missing");
  a_res_hold: assert property (p_res_hold) else $error("result changed without event");
  a_cfg_hold: assert property (p_cfg_hold) else $error("settings changed mid measurement");
  a_hits: assert property (p_hits) else $error("hit count above four");
endmodule : tcr_bank_assertions
bind tcr_config_bank tcr_bank_assertions tcr_bank_assertions_i (.i_clk, .i_reset, .i_address, .i_read, .i_write,
  .i_meas_start, .i_timeout, .i_alu_done, .i_alu_diff, .o_readdata, .o_waitrequest, .o_alu_result, .o_cfg);
`default_nettype wire

// file: sim/tcr_config_bank_tb.sv
// Self-checking bench of the TDC configuration bank
`default_nettype none
module tcr_config_bank_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic i_clk = 0, i_reset = 1, i_read = 0, i_write = 0;
  logic i_meas_start = 0, i_timeout = 0, i_end_hits = 0, i_alu_done = 0;
  logic [5:0] i_address = 6'h0;
  logic [3:0] i_byteenable = 4'hf;
  logic [31:0] i_writedata = 32'h0, i_alu_diff = 32'h0, o_readdata, o_alu_result, d;
  logic o_waitrequest, o_irq;
  tcr_pkg::tcr_active_t o_cfg;
  int err_count = 0, n_tests = 0, cyc = 0;
  tcr_config_bank tcr_config_bank_i (.i_clk, .i_reset, .i_address, .i_read, .i_write, .i_writedata,
    .i_byteenable, .o_readdata, .o_waitrequest, .i_meas_start, .i_timeout, .i_end_hits,
    .i_alu_done, .i_alu_diff, .o_alu_result, .o_cfg, .o_irq);
  // ****************
  // Helpers
  // ****************
  initial forever #2 i_clk = ~i_clk;
  task automatic complete_run;
    if (err_count == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : complete_run
  // Hang guard, the whole run needs under a hundred cycles
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      complete_run();
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      err_count++;
      $display("unexpected %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  // Waitrequest and read data are taken at the rising edge, before the design updates them
  task automatic bus(input logic rd, input logic [5:0] a, input logic [31:0] w);
    @(posedge i_clk);
    i_address <= a;
    i_writedata <= w;
    i_read <= rd;
    i_write <= !rd;
    do @(posedge i_clk); while (o_waitrequest !== 1'b0);
    d = o_readdata;
    i_read <= 1'b0;
    i_write <= 1'b0;
  endtask : bus
  task automatic ev(input logic [3:0] m);
    @(posedge i_clk);
    {i_meas_start, i_timeout, i_end_hits, i_alu_done} <= m;
    @(posedge i_clk);
    {i_meas_start, i_timeout, i_end_hits, i_alu_done} <= 4'h0;
    @(negedge i_clk);
  endtask : ev
  task automatic irq_is(input logic e);
    @(posedge i_clk);
    @(negedge i_clk);
    chk("irq", {31'h0, e}, {31'h0, o_irq});
  endtask : irq_is
  // ****************
  // Scenarios
  // ****************
  task automatic t_reset;
    chk("cfg zero", 32'h1, {31'h0, o_cfg === '0});
    chk("irq reset", 32'h0, {31'h0, o_irq});
    bus(1, 6'h18, 32'h0);
    chk("ctrl reset", 32'h8, d);
    ev(4'h8);
    chk("default operands", 32'h55, {24'h0, o_cfg.op_a, o_cfg.op_b});
    chk("default hits", 32'h0, {26'h0, o_cfg.hits_a, o_cfg.hits_b});
    chk("default timeout", 32'h4000, {16'h0, o_cfg.timeout_ref});
    chk("default range", 32'h1, {31'h0, o_cfg.range_b});
    chk("default outputs", 32'h6, {29'h0, o_cfg.pulse_a_en, o_cfg.pulse_b_en, o_cfg.pulse_b_inv});
  endtask : t_reset
  task automatic t_config;
    bus(0, 6'h04, 32'h00299c00);
    bus(0, 6'h08, 32'h00efffff);
    bus(0, 6'h0c, 32'h00300001);
    bus(0, 6'h10, 32'h00040000);
    bus(0, 6'h14, 32'h00bfa5c3);
    chk("cfg before start", 32'h55, {24'h0, o_cfg.op_a, o_cfg.op_b});
    ev(4'h8);
    chk("hits a", 32'h4, {29'h0, o_cfg.hits_a});
    chk("hits b", 32'h3, {29'h0, o_cfg.hits_b});
    chk("fast init", 32'h1, {31'h0, o_cfg.fast_init});
    chk("operands", 32'h92, {24'h0, o_cfg.op_a, o_cfg.op_b});
    chk("delay a", 32'h7ffff, {13'h0, o_cfg.delay_a});
    chk("delay b", 32'h1, {13'h0, o_cfg.delay_b});
    chk("delay c", 32'h40000, {13'h0, o_cfg.delay_c});
    chk("edges", 32'h2, {30'h0, o_cfg.dual_a, o_cfg.dual_b});
    chk("timeout ref", 32'h1000, {16'h0, o_cfg.timeout_ref});
    chk("err fill", 32'h1, {31'h0, o_cfg.err_fill});
    chk("phase", 32'ha5c3, {16'h0, o_cfg.phase});
    chk("repeat", 32'h7, {29'h0, o_cfg.repeat_n});
    chk("start jitter", 32'h1, {31'h0, o_cfg.start_jitter});
    chk("outputs", 32'h3, {29'h0, o_cfg.pulse_a_en, o_cfg.pulse_b_en, o_cfg.pulse_b_inv});
    chk("range b", 32'h1, {31'h0, o_cfg.range_b});
    bus(0, 6'h08, 32'h00f7ffff);
    bus(0, 6'h18, 32'h00000000);
    chk("dual b held", 32'h0, {31'h0, o_cfg.dual_b});
    ev(4'h8);
    chk("dual b new", 32'h1, {31'h0, o_cfg.dual_b});
    chk("range a", 32'h0, {31'h0, o_cfg.range_b});
  endtask : t_config
  task automatic t_refuse;
    bus(1, 6'h04, 32'h0);
    chk("write only read", 32'h0, d);
    bus(1, 6'h3c, 32'h0);
    chk("unmapped read", 32'h0, d);
  endtask : t_refuse
  task automatic t_events;
    bus(0, 6'h20, 32'h00000007);
    bus(1, 6'h20, 32'h0);
    chk("mask read", 32'h7, d);
    i_alu_diff <= 32'h12345678;
    ev(4'h1);
    chk("alu result", 32'h12345678, o_alu_result);
    irq_is(1'b1);
    bus(1, 6'h1c, 32'h0);
    chk("status alu", 32'h1, d);
    irq_is(1'b0);
    ev(4'h4);
    chk("error fill", 32'hffffffff, o_alu_result);
    bus(1, 6'h1c, 32'h0);
    chk("status timeout", 32'h4, d);
    bus(0, 6'h20, 32'h00000000);
    ev(4'h2);
    irq_is(1'b0);
    bus(1, 6'h1c, 32'h0);
    chk("status hits", 32'h2, d);
  endtask : t_events
  // Single byte lane write, then a timeout in the same cycle as ALU done with the error fill switched off
  task automatic t_lanes;
    i_alu_diff <= 32'h0badcafe;
    i_byteenable <= 4'h1;
    bus(0, 6'h08, 32'h00000012);
    i_byteenable <= 4'hf;
    bus(0, 6'h0c, 32'h00000000);
    ev(4'h8);
    chk("byte lane", 32'h7ff12, {13'h0, o_cfg.delay_a});
    chk("timeout short", 32'h100, {16'h0, o_cfg.timeout_ref});
    chk("err fill off", 32'h0, {31'h0, o_cfg.err_fill});
    ev(4'h5);
    chk("no fill", 32'h0badcafe, o_alu_result);
  endtask : t_lanes
  initial begin
    repeat (4) @(posedge i_clk);
    i_reset <= 1'b0;
    @(negedge i_clk);
    t_reset();
    t_config();
    t_refuse();
    t_events();
    t_lanes();
    complete_run();
  end
endmodule : tcr_config_bank_tb
`default_nettype wire
